// [common/mct_map.vh]
`ifndef MCT_MAP_VH
`define MCT_MAP_VH

// Register byte addresses
`define MCT_ADDR_CTRL     8'h00
`define MCT_ADDR_STRETCH  8'h04
`define MCT_ADDR_STATUS   8'h08

// Control register fields
`define MCT_CTRL_SLOW     0
`define MCT_CTRL_TFAST    1
`define MCT_CTRL_EMI      2
`define MCT_CTRL_RST      3'h0

// Status register fields
`define MCT_ST_SLOW       0
`define MCT_ST_TFAST      1
`define MCT_ST_EMI        2
`define MCT_ST_EXT_BUSY   3
`define MCT_ST_INS_BUSY   4

// Machine cycle phase terminal counts (clocks per cycle minus one)
`define MCT_PH_STD_LAST   10'h003
`define MCT_PH_SLOW_LAST  10'h3FF

// Timer prescale terminal counts
`define MCT_TP_STD_LAST   4'hB
`define MCT_TP_FAST_LAST  4'h3

// Access stretch limits in machine cycles
`define MCT_STR_MIN       4'h2
`define MCT_STR_MAX       4'hC
`define MCT_STR_RST       4'h2

// Instruction length limits in machine cycles
`define MCT_INS_MIN       4'h1
`define MCT_INS_MAX       4'h5

// Countdown value held during the final machine cycle
`define MCT_CNT_LAST      4'h1

`endif

// [design/mct_timing.v]
`timescale 1ns/100ps
`include "mct_map.vh"

module mct_timing #(
   // Phase and prescale terminal counts, clocks per period minus one
   parameter [9:0] PH_STD_LAST  = `MCT_PH_STD_LAST,
   parameter [9:0] PH_SLOW_LAST = `MCT_PH_SLOW_LAST,
   parameter [3:0] TP_STD_LAST  = `MCT_TP_STD_LAST,
   parameter [3:0] TP_FAST_LAST = `MCT_TP_FAST_LAST,
   // Limits in machine cycles; counters are four bits, so keep them under 16
   parameter [3:0] STR_MIN      = `MCT_STR_MIN,
   parameter [3:0] STR_MAX      = `MCT_STR_MAX,
   parameter [3:0] INS_MIN      = `MCT_INS_MIN,
   parameter [3:0] INS_MAX      = `MCT_INS_MAX
) (
   // Clock and reset
   input  wire       clk_i,
   input  wire       rst_i,
   // Register port
   input  wire [7:0] reg_addr_i,
   input  wire [7:0] reg_wdata_i,
   input  wire       reg_wr_i,
   input  wire       reg_rd_i,
   output wire [7:0] reg_rdata_o,
   // Core requests
   input  wire       ext_data_move_i,
   input  wire       ext_bus_need_i,
   input  wire       instr_start_i,
   input  wire [2:0] instr_len_i,
   // Timing outputs
   output wire       mcycle_o,
   output wire       ale_o,
   output wire       timer_tick_o,
   output wire       ext_busy_o,
   output wire       ext_done_o,
   output wire       instr_busy_o,
   output wire       instr_done_o
);

   ////////////////////////////////////////////////////////////////////////
   // Saturating range limit shared by stretch and instruction length
   // Out-of-range settings saturate instead of being refused
   function [3:0] mct_clamp;
      input [3:0] v;
      input [3:0] lo;
      input [3:0] hi;
      begin
         if (v < lo) begin
            mct_clamp = lo;
         end else if (v > hi) begin
            mct_clamp = hi;
         end else begin
            mct_clamp = v;
         end
      end
   endfunction

   // Final machine cycle of a countdown, shared by both sequencers
   function mct_on_last;
      input [3:0] cnt;
      begin
         mct_on_last = (cnt == `MCT_CNT_LAST);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Software settings as written, live until the next boundary
   reg  [2:0] ctrl_q;
   reg  [3:0] stretch_q;
   reg  [7:0] rdata_q;

   // Applied copies, loaded only when a machine cycle closes
   reg        act_slow_q;
   reg        act_tfast_q;
   reg        act_emi_q;

   // Phase and prescale counters with their registered pulses
   reg  [9:0] ph_q;
   reg  [3:0] tp_q;
   reg        tick_q;
   reg        mcyc_q;
   reg        ale_q;

   // External data move sequencer
   reg        ext_pend_q;
   reg        ext_busy_q;
   reg  [3:0] ext_cnt_q;
   reg        ext_done_q;

   // Instruction sequencer
   reg        ins_pend_q;
   reg  [3:0] ins_len_q;
   reg        ins_busy_q;
   reg  [3:0] ins_cnt_q;
   reg        ins_done_q;

   // Status word assembled from the applied state
   reg  [7:0] status_word;

   // Decoded terminal conditions
   wire [9:0] ph_last;
   wire       cyc_end;
   wire [3:0] tp_last;
   wire       tp_end;
   wire [3:0] str_next;
   wire       ext_last;
   wire       ins_last;
   wire       bus_need;

   // Terminal counts come from the applied copies, never the live register
   assign ph_last  = act_slow_q ? PH_SLOW_LAST : PH_STD_LAST;
   assign cyc_end  = (ph_q == ph_last);
   assign tp_last  = act_tfast_q ? TP_FAST_LAST : TP_STD_LAST;
   // Compare with >= so a switch to fast mode never overruns the counter
   assign tp_end   = (tp_q >= tp_last);
   assign str_next = mct_clamp(stretch_q, STR_MIN, STR_MAX);
   assign ext_last = mct_on_last(ext_cnt_q);
   assign ins_last = mct_on_last(ins_cnt_q);
   // Strobe is wanted next cycle if an access runs on or is queued
   assign bus_need = ext_bus_need_i | ext_pend_q |
                     (ext_busy_q & ~ext_last);

   // Status bits sit at their own positions; spare bits read as zero
   always @* begin
      status_word                     = 8'h00;
      status_word[`MCT_ST_SLOW]       = act_slow_q;
      status_word[`MCT_ST_TFAST]      = act_tfast_q;
      status_word[`MCT_ST_EMI]        = act_emi_q;
      status_word[`MCT_ST_EXT_BUSY]   = ext_busy_q;
      status_word[`MCT_ST_INS_BUSY]   = ins_busy_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes
   // Unmapped offsets are dropped; spare data bits are ignored
   always @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q    <= `MCT_CTRL_RST;
         stretch_q <= `MCT_STR_RST;
      end else if (reg_wr_i) begin
         if (reg_addr_i == `MCT_ADDR_CTRL) begin
            ctrl_q <= reg_wdata_i[2:0];
         end
         if (reg_addr_i == `MCT_ADDR_STRETCH) begin
            stretch_q <= reg_wdata_i[3:0];
         end
      end
   end

   // Read data stands one cycle after the strobe, zero otherwise
   always @(posedge clk_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `MCT_ADDR_CTRL: begin
               rdata_q <= {5'h00, ctrl_q};
            end
            `MCT_ADDR_STRETCH: begin
               rdata_q <= {4'h0, stretch_q};
            end
            `MCT_ADDR_STATUS: begin
               rdata_q <= status_word;
            end
            // Unmapped offsets read as zero rather than aliasing
            default: begin
               rdata_q <= 8'h00;
            end
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Settings are copied only when a machine cycle closes
   // so a cycle already running is never cut short or stretched
   always @(posedge clk_i) begin
      if (rst_i) begin
         act_slow_q  <= 1'b0;
         act_tfast_q <= 1'b0;
         act_emi_q   <= 1'b0;
      end else if (cyc_end) begin
         act_slow_q  <= ctrl_q[`MCT_CTRL_SLOW];
         act_tfast_q <= ctrl_q[`MCT_CTRL_TFAST];
         act_emi_q   <= ctrl_q[`MCT_CTRL_EMI];
      end
   end

   // Machine cycle phase counter, strobe and cycle pulse
   always @(posedge clk_i) begin
      if (rst_i) begin
         ph_q   <= 10'h000;
         mcyc_q <= 1'b0;
         ale_q  <= 1'b0;
      end else begin
         if (cyc_end) begin
            ph_q <= 10'h000;
         end else begin
            ph_q <= ph_q + 10'h001;
         end
         mcyc_q <= cyc_end;
         // Suppressed strobe cuts emission when the bus is idle; the live
         // enable bit is read on the boundary edge that applies it
         ale_q  <= cyc_end &
                   (~ctrl_q[`MCT_CTRL_EMI] | bus_need);
      end
   end

   // Timer prescaler runs on oscillator clocks, not machine cycles
   // The count carries over a mode switch, so one period may be odd
   always @(posedge clk_i) begin
      if (rst_i) begin
         tp_q   <= 4'h0;
         tick_q <= 1'b0;
      end else begin
         if (tp_end) begin
            tp_q <= 4'h0;
         end else begin
            tp_q <= tp_q + 4'h1;
         end
         tick_q <= tp_end;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // External data move: queued, started at a boundary, counted in cycles
   // Limitation: one request queues; repeats while pending merge into it
   // Busy counts whole cycles down; done marks the closing boundary
   always @(posedge clk_i) begin
      if (rst_i) begin
         ext_pend_q <= 1'b0;
         ext_busy_q <= 1'b0;
         ext_cnt_q  <= 4'h0;
         ext_done_q <= 1'b0;
      end else begin
         // A new request beats the clear in the same cycle
         if (ext_data_move_i) begin
            ext_pend_q <= 1'b1;
         end else if (cyc_end & (~ext_busy_q | ext_last)) begin
            ext_pend_q <= 1'b0;
         end
         if (cyc_end) begin
            if (ext_busy_q & ~ext_last) begin
               ext_cnt_q <= ext_cnt_q - 4'h1;
            end else if (ext_pend_q) begin
               ext_busy_q <= 1'b1;
               ext_cnt_q  <= str_next;
            end else begin
               ext_busy_q <= 1'b0;
               ext_cnt_q  <= 4'h0;
            end
         end
         ext_done_q <= cyc_end & ext_busy_q & ext_last;
      end
   end

   // Instruction sequencing in whole machine cycles
   // Length is captured with the start pulse; later values are ignored
   always @(posedge clk_i) begin
      if (rst_i) begin
         ins_pend_q <= 1'b0;
         ins_len_q  <= INS_MIN;
         ins_busy_q <= 1'b0;
         ins_cnt_q  <= 4'h0;
         ins_done_q <= 1'b0;
      end else begin
         if (instr_start_i) begin
            ins_pend_q <= 1'b1;
            ins_len_q  <= mct_clamp({1'b0, instr_len_i},
                                    INS_MIN, INS_MAX);
         end else if (cyc_end & (~ins_busy_q | ins_last)) begin
            ins_pend_q <= 1'b0;
         end
         if (cyc_end) begin
            if (ins_busy_q & ~ins_last) begin
               ins_cnt_q <= ins_cnt_q - 4'h1;
            end else if (ins_pend_q) begin
               ins_busy_q <= 1'b1;
               ins_cnt_q  <= ins_len_q;
            end else begin
               ins_busy_q <= 1'b0;
               ins_cnt_q  <= 4'h0;
            end
         end
         ins_done_q <= cyc_end & ins_busy_q & ins_last;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   // Register port
   assign reg_rdata_o  = rdata_q;

   // Cycle, strobe and timer pulses
   assign mcycle_o     = mcyc_q;
   assign ale_o        = ale_q;
   assign timer_tick_o = tick_q;

   // Sequencer status
   assign ext_busy_o   = ext_busy_q;
   assign ext_done_o   = ext_done_q;
   assign instr_busy_o = ins_busy_q;
   assign instr_done_o = ins_done_q;

endmodule

// [verification/mct_timing_assertions.sv]
`timescale 1ns/100ps
module mct_timing_assertions (
   // Clock, reset and register port
   input logic       clk_i, rst_i, reg_wr_i, reg_rd_i,
   input logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o,
   // Core requests
   input logic       ext_data_move_i, ext_bus_need_i, instr_start_i,
   input logic [2:0] instr_len_i,
   // Timing outputs
   input logic       mcycle_o, ale_o, timer_tick_o, ext_busy_o,
   input logic       ext_done_o, instr_busy_o, instr_done_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [10:0] gap_q;
   ////////////////////////////////////////////////////////////////////////
   // Clocks since the last cycle pulse; the preset makes the first gap 3
   always @(posedge clk_i) begin
      if (rst_i) gap_q <= 11'h7FF;
      else if (mcycle_o) gap_q <= 11'h000;
      else gap_q <= gap_q + 11'h001;
   end
   sequence s_quiet3; !mcycle_o [*3]; endsequence
   sequence s_hold8; ext_busy_o [*8]; endsequence
   ////////////////////////////////////////////////////////////////////////
   a_cycle_gap: assert property (mcycle_o |=> s_quiet3)
      else $error("cycle pulses closer than four clocks");
   a_cycle_len: assert property (mcycle_o |->
      (gap_q == 11'h003 || gap_q == 11'h3FF))
      else $error("cycle length neither 4 nor 1024");
   a_ale_cycle: assert property (ale_o |-> mcycle_o)
      else $error("strobe outside a cycle start");
   a_ale_need: assert property (
      mcycle_o && $past(ext_bus_need_i) |-> ale_o)
      else $error("strobe missing while bus needed");
   a_tick_gap: assert property (timer_tick_o |=> !timer_tick_o [*3])
      else $error("timer ticks closer than four clocks");
   a_ext_min: assert property ($rose(ext_busy_o) |-> s_hold8)
      else $error("data move shorter than eight clocks");
   a_ext_bound: assert property ($rose(ext_busy_o) |-> mcycle_o)
      else $error("data move started off a boundary");
   a_ext_done: assert property (
      $fell(ext_busy_o) |-> ext_done_o && mcycle_o)
      else $error("data move ended without done");
   a_instr_min: assert property (
      $rose(instr_busy_o) |-> instr_busy_o [*4])
      else $error("instruction shorter than one cycle");
   a_instr_done: assert property (instr_done_o |-> mcycle_o)
      else $error("instruction done off a boundary");
   a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside its cycle");
endmodule
bind mct_timing mct_timing_assertions CHK (.clk_i(clk_i), .rst_i(rst_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
   .ext_data_move_i(ext_data_move_i), .ext_bus_need_i(ext_bus_need_i),
   .instr_start_i(instr_start_i), .instr_len_i(instr_len_i),
   .mcycle_o(mcycle_o), .ale_o(ale_o), .timer_tick_o(timer_tick_o),
   .ext_busy_o(ext_busy_o), .ext_done_o(ext_done_o),
   .instr_busy_o(instr_busy_o), .instr_done_o(instr_done_o));

// [verification/mct_ext_mem.sv]
`timescale 1ns/100ps
module mct_ext_mem (
   input  logic clk_i,
   input  logic rst_i,
   input  logic want_i,
   input  logic ale_i,
   output logic need_o,
   output int   ale_cnt_o
);
   // Slow decoder: asks for the bus one clock late, counts every strobe
   always @(posedge clk_i) begin
      need_o <= !rst_i && want_i;
      if (rst_i) ale_cnt_o <= 0;
      else if (ale_i) ale_cnt_o <= ale_cnt_o + 1;
   end
endmodule

// [verification/mct_timing_bench.sv]
`timescale 1ns/100ps
`include "mct_map.vh"
module mct_timing_bench;
   logic       clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, d;
   logic       move_i = 0, start_i = 0, want = 0, need;
   logic [2:0] len_i = 3'h0;
   logic       mcycle_o, ale_o, timer_tick_o, ext_busy_o, instr_busy_o;
   logic       ext_done_o, instr_done_o;
   int         num_errors = 0, compares = 0, cyc = 0, ale_cnt, n, a;
   int         exp_q[$];
   always #20 clk_i = ~clk_i;
   mct_timing DUT (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .ext_data_move_i(move_i),
      .ext_bus_need_i(need), .instr_start_i(start_i), .instr_len_i(len_i),
      .mcycle_o(mcycle_o), .ale_o(ale_o), .timer_tick_o(timer_tick_o),
      .ext_busy_o(ext_busy_o), .ext_done_o(ext_done_o),
      .instr_busy_o(instr_busy_o), .instr_done_o(instr_done_o));
   mct_ext_mem PEER (.clk_i(clk_i), .rst_i(rst_i), .want_i(want),
      .ale_i(ale_o), .need_o(need), .ale_cnt_o(ale_cnt));
   ////////////////////////////////////////////////////////////////////////
   task report_and_stop;
      $display("Errors %0d of %0d compares", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Hang guard: the whole sequence needs about 3000 clocks
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         report_and_stop;
      end
   end
   task wr(input logic [7:0] ad, input logic [7:0] v);
      @(posedge clk_i);
      reg_addr_i <= ad;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task rd(input logic [7:0] ad, output logic [7:0] v);
      @(posedge clk_i);
      reg_addr_i <= ad;
      reg_rd_i <= 1'b1;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      @(negedge clk_i);
      v = reg_rdata_o;
   endtask
   task kick(input logic ext, input logic [2:0] l);
      @(posedge clk_i);
      move_i <= ext;
      start_i <= !ext;
      len_i <= l;
      @(posedge clk_i);
      move_i <= 1'b0;
      start_i <= 1'b0;
   endtask
   function logic sig(input int s);
      case (s)
         0: sig = mcycle_o;
         1: sig = timer_tick_o;
         2: sig = ext_busy_o;
         default: sig = instr_busy_o;
      endcase
   endfunction
   // Pulses give the period, busy levels give the high time
   task meas(input int s, output int len);
      while (sig(s) !== 1'b1) @(negedge clk_i);
      len = 0;
      do begin
         @(negedge clk_i);
         len++;
      end while (sig(s) === (s > 1));
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      a = $urandom(32'h7fd0);
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(`MCT_ADDR_STRETCH, d);
      chk(d, 8'h02);
      wr(8'h0C, 8'hFF);
      rd(8'h0C, d);
      chk(d, 8'h00);
      meas(0, n);
      chk(n, 4);
      meas(1, n);
      chk(n, 12);
      a = ale_cnt;
      repeat (12) @(negedge clk_i);
      chk(ale_cnt - a, 3);
      wr(`MCT_ADDR_CTRL, 8'h02);
      meas(1, n);
      meas(1, n);
      chk(n, 4);
      rd(`MCT_ADDR_STATUS, d);
      chk(d, 8'h02);
      for (int s = 0; s < 16; s++) begin
         wr(`MCT_ADDR_STRETCH, s[7:0]);
         exp_q.push_back(4 * (s < 2 ? 2 : (s > 12 ? 12 : s)));
         kick(1'b1, 3'h0);
         meas(2, n);
         chk(n, exp_q.pop_front());
         chk(ext_done_o, 1'b1);
      end
      repeat (8) begin
         a = $urandom % 8;
         exp_q.push_back(4 * (a < 1 ? 1 : (a > 5 ? 5 : a)));
         kick(1'b0, a[2:0]);
         meas(3, n);
         chk(n, exp_q.pop_front());
         chk(instr_done_o, 1'b1);
      end
      wr(`MCT_ADDR_CTRL, 8'h04);
      repeat (8) @(negedge clk_i);
      a = ale_cnt;
      repeat (40) @(negedge clk_i);
      chk(ale_cnt - a, 0);
      want <= 1'b1;
      repeat (4) @(negedge clk_i);
      a = ale_cnt;
      repeat (12) @(negedge clk_i);
      chk(ale_cnt - a, 3);
      want <= 1'b0;
      wr(`MCT_ADDR_CTRL, 8'h01);
      meas(0, n);
      meas(0, n);
      chk(n, 1024);
      rd(`MCT_ADDR_STATUS, d);
      chk(d, 8'h01);
      report_and_stop;
   end
endmodule
